// ---- common/dha_pkg.sv ----
// Package with register map, field layout, reset values and state codes of the DMA handshake block.
package dha_pkg;
	// Register word indices on the Avalon-MM slave.
	localparam logic [2:0] REG_CTRL     = 3'h0;
	localparam logic [2:0] REG_TXBC_HI  = 3'h1;
	localparam logic [2:0] REG_TXBC_LO  = 3'h2;
	localparam logic [2:0] REG_IRQ_STAT = 3'h3;
	localparam logic [2:0] REG_IRQ_MASK = 3'h4;
	localparam logic [2:0] REG_PINS     = 3'h5;
	localparam logic [2:0] REG_GPIO_OUT = 3'h6;
	localparam logic [2:0] REG_TX_LEFT  = 3'h7;
	// Control register fields.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_AUX_PIN_2_LSB = 2;
	localparam int CTRL_START    = 4;
	// Operating modes.
	localparam logic [1:0] MODE_TERMINAL = 2'h0;
	localparam logic [1:0] MODE_TRUNK    = 2'h1;
	localparam logic [1:0] MODE_SUBSCR   = 2'h2;
	// Uses of auxiliary pin 2 in terminal mode.
	localparam logic [1:0] AUX_PIN_2_GPIO_IN  = 2'h0;
	localparam logic [1:0] AUX_PIN_2_GPIO_OUT = 2'h1;
	localparam logic [1:0] AUX_PIN_2_INT      = 2'h2;
	// Byte count register widths.
	localparam int BC_HI_W = 4;
	localparam int BC_LO_W = 8;
	localparam int BC_W    = BC_HI_W + BC_LO_W;
	// Block sizes in bytes.
	localparam logic [6:0] TX_BLOCK_BYTES = 7'h40;
	localparam logic [6:0] RX_BLOCK_MAX   = 7'h40;
	// Interrupt status bits.
	localparam int IRQ_W       = 3;
	localparam int IRQ_TX_DONE = 0;
	localparam int IRQ_TX_BLK  = 1;
	localparam int IRQ_RX_BLK  = 2;
	// Pin status register fields.
	localparam int PINS_AUX_PIN_2  = 0;
	localparam int PINS_CHSEL = 1;
	localparam int PINS_TXBSY = 4;
	localparam int PINS_RXBSY = 5;
	// Reset values.
	localparam logic [1:0]       MODE_RST = MODE_TERMINAL;
	localparam logic [1:0]       AUX_PIN_2_RST = AUX_PIN_2_GPIO_IN;
	localparam logic [BC_W-1:0]  BC_RST   = 12'h000;
	localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;
	// Transmit request sequencer states.
	typedef enum logic [2:0] {
		DHA_TX_IDLE = 3'b001,
		DHA_TX_WAIT = 3'b010,
		DHA_TX_REQ  = 3'b100
	} dha_tx_state_t;
	// Receive request sequencer states.
	typedef enum logic [1:0] {
		DHA_RX_IDLE = 2'b01,
		DHA_RX_REQ  = 2'b10
	} dha_rx_state_t;
endpackage

// ---- design/dha_top.sv ----
// DMA request and acknowledge handshake with mode-dependent auxiliary pins 0 to 2.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Acknowledge low acts as chip select: read pops receive, write pushes transmit.
// - While acknowledge is low the address pins are ignored; the FIFO is implied.
// - Terminal mode: transmit request stays high while the transmit FIFO needs data.
// - Transmit data is requested in 64-byte blocks plus a remainder block.
// - Transmit request drops right after the falling edge of the block's last write.
// - Terminal mode: receive request high while the receive FIFO holds a 64..4 byte block.
// - Receive request drops right after the falling edge of the block's last read.
// - Line modes: auxiliary pins 0 to 2 are inputs selecting one of eight channels.
// - Line modes: auxiliary pin 0 is channel select bit 0 instead of transmit request.
// - Terminal mode: auxiliary pin 2 is a general-purpose input or output.
// - Terminal mode: auxiliary pin 2 may output the inverse of the main interrupt.
// - Main interrupt is active low, open drain, asserted while an interrupt pends.
module dha_top (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Avalon-MM register slave.
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Host bus pins.
	input  wire logic        dma_ack_chan_a_n,
	input  wire logic        dma_ack_chan_b_n,
	input  wire logic        host_cs_n,
	input  wire logic        host_rd_n,
	input  wire logic        host_wr_n,
	input  wire logic [7:0]  host_addr,
	// FIFO side, same clock.
	input  wire logic        tx_fifo_room,
	input  wire logic        rx_block_ready,
	input  wire logic [2:0]  rx_block_code,
	input  wire logic        dev_int_pending,
	output logic             tx_push_chan_a,
	output logic             rx_pop_chan_a,
	output logic             tx_push_chan_b,
	output logic             rx_pop_chan_b,
	output logic             reg_rd_pulse,
	output logic             reg_wr_pulse,
	output logic      [7:0]  reg_addr,
	// Auxiliary pins and channel select.
	input  wire logic [2:0]  aux_pin_in,
	output logic      [2:0]  aux_pin_out,
	output logic      [2:0]  aux_pin_oe_n,
	output logic      [2:0]  chan_sel,
	// Interrupts.
	output logic             int_pin_out,
	output logic             int_pin_oe_n,
	output logic             irq
);
	// Two-flop synchroniser stages for every pin input, plus one stage for edge detection.
	localparam int SW = 16;
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic [SW-1:0] sync3_r;
	logic [SW-1:0] pins_raw;
	assign pins_raw = {aux_pin_in, host_addr, host_wr_n, host_rd_n, dma_ack_chan_b_n, dma_ack_chan_a_n, host_cs_n};

	// Pins pass two flops before any logic reads them; the first flop feeds only the second.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			{sync1_r, sync2_r, sync3_r} <= {(3 * SW){1'b1}};
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	logic       cs_n_s, ack_a_n_s, ack_b_n_s, rd_fall, wr_fall;
	logic [7:0] addr_s;
	logic [2:0] aux_s;
	assign cs_n_s    = sync2_r[0];
	assign ack_a_n_s = sync2_r[1];
	assign ack_b_n_s = sync2_r[2];
	assign rd_fall   = sync3_r[3] & ~sync2_r[3];
	assign wr_fall   = sync3_r[4] & ~sync2_r[4];
	assign addr_s    = sync2_r[12:5];
	assign aux_s     = sync2_r[15:13];

	// Strobe falling edges qualified by acknowledge; acknowledge alone does nothing.
	logic push_a, pop_a, push_b, pop_b, any_ack;
	assign push_a  = ~ack_a_n_s & wr_fall;
	assign pop_a   = ~ack_a_n_s & rd_fall;
	assign push_b  = ~ack_b_n_s & wr_fall;
	assign pop_b   = ~ack_b_n_s & rd_fall;
	assign any_ack = ~ack_a_n_s | ~ack_b_n_s;

	// FIFO access pulses; register accesses only when no acknowledge selects a FIFO.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			{tx_push_chan_a, rx_pop_chan_a, tx_push_chan_b, rx_pop_chan_b, reg_rd_pulse, reg_wr_pulse} <= 6'h00;
			reg_addr       <= 8'h00;
		end else begin
			{tx_push_chan_a, rx_pop_chan_a, tx_push_chan_b, rx_pop_chan_b} <= {push_a, pop_a, push_b, pop_b};
			reg_rd_pulse   <= ~any_ack & ~cs_n_s & rd_fall;
			reg_wr_pulse   <= ~any_ack & ~cs_n_s & wr_fall;
			if (~any_ack & ~cs_n_s & (rd_fall | wr_fall)) begin
				reg_addr <= addr_s;
			end
		end
	end

	// Software-visible state.
	logic [1:0]                mode_r;
	logic [1:0]                aux_pin_2_use_r;
	logic [dha_pkg::BC_W-1:0]  txbc_r;
	logic [dha_pkg::IRQ_W-1:0] irq_stat_r;
	logic [dha_pkg::IRQ_W-1:0] irq_mask_r;
	logic                      gpio_out_r;
	logic                      wr_take, rd_take, start_pulse, term_mode;
	assign wr_take     = avs_write & ~avs_waitrequest;
	assign rd_take     = avs_read & avs_waitrequest;
	assign start_pulse = wr_take & (avs_address == dha_pkg::REG_CTRL) & avs_writedata[dha_pkg::CTRL_START];
	assign term_mode   = (mode_r == dha_pkg::MODE_TERMINAL);

	// Control, byte count, mask and GPIO registers.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mode_r     <= dha_pkg::MODE_RST;
			aux_pin_2_use_r <= dha_pkg::AUX_PIN_2_RST;
			txbc_r     <= dha_pkg::BC_RST;
			irq_mask_r <= dha_pkg::IRQ_RST;
			gpio_out_r <= 1'b0;
		end else if (wr_take) begin
			unique case (avs_address)
				dha_pkg::REG_CTRL: begin
					mode_r     <= avs_writedata[dha_pkg::CTRL_MODE_LSB +: 2];
					aux_pin_2_use_r <= avs_writedata[dha_pkg::CTRL_AUX_PIN_2_LSB +: 2];
				end
				dha_pkg::REG_TXBC_HI: txbc_r[dha_pkg::BC_W-1 -: dha_pkg::BC_HI_W] <= avs_writedata[dha_pkg::BC_HI_W-1:0];
				dha_pkg::REG_TXBC_LO: txbc_r[dha_pkg::BC_LO_W-1:0] <= avs_writedata[dha_pkg::BC_LO_W-1:0];
				dha_pkg::REG_IRQ_MASK: irq_mask_r <= avs_writedata[dha_pkg::IRQ_W-1:0];
				dha_pkg::REG_GPIO_OUT: gpio_out_r <= avs_writedata[0];
				default: ;
			endcase
		end
	end

	// Transmit sequencer: whole 64-byte blocks, then the remainder, until the count is done.
	dha_pkg::dha_tx_state_t   tx_state_r, tx_state_nxt;
	logic [dha_pkg::BC_W-1:0] tx_left_r, tx_left_nxt;
	logic [6:0]               tx_blk_r, tx_blk_nxt;
	logic                     tx_done_ev, tx_blk_ev;
	always_comb begin
		tx_state_nxt = tx_state_r;
		tx_left_nxt  = tx_left_r;
		tx_blk_nxt   = tx_blk_r;
		tx_done_ev   = 1'b0;
		tx_blk_ev    = 1'b0;
		unique case (tx_state_r)
			dha_pkg::DHA_TX_IDLE: begin
				if (start_pulse && term_mode) begin
					tx_left_nxt  = txbc_r;
					tx_state_nxt = dha_pkg::DHA_TX_WAIT;
				end
			end
			dha_pkg::DHA_TX_WAIT: begin
				if (tx_left_r == '0) begin
					tx_done_ev   = 1'b1;
					tx_state_nxt = dha_pkg::DHA_TX_IDLE;
				end else if (tx_fifo_room) begin
					if (tx_left_r >= dha_pkg::BC_W'(dha_pkg::TX_BLOCK_BYTES)) begin
						tx_blk_nxt = dha_pkg::TX_BLOCK_BYTES;
					end else begin
						tx_blk_nxt = tx_left_r[6:0];
					end
					tx_state_nxt = dha_pkg::DHA_TX_REQ;
				end
			end
			dha_pkg::DHA_TX_REQ: begin
				if (push_a) begin
					tx_left_nxt = tx_left_r - 1'b1;
					tx_blk_nxt  = tx_blk_r - 1'b1;
					if (tx_blk_r == 7'h01) begin
						tx_blk_ev    = 1'b1;
						tx_state_nxt = dha_pkg::DHA_TX_WAIT;
					end
				end
			end
			default: tx_state_nxt = dha_pkg::DHA_TX_IDLE;
		endcase
	end

	// Transmit sequencer state.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_state_r <= dha_pkg::DHA_TX_IDLE;
			tx_left_r  <= dha_pkg::BC_RST;
			tx_blk_r   <= 7'h00;
		end else begin
			tx_state_r <= tx_state_nxt;
			tx_left_r  <= tx_left_nxt;
			tx_blk_r   <= tx_blk_nxt;
		end
	end

	// Receive sequencer: one request per block of 64, 32, 16, 8 or 4 bytes.
	dha_pkg::dha_rx_state_t rx_state_r, rx_state_nxt;
	logic [6:0]             rx_blk_r, rx_blk_nxt;
	logic                   rx_blk_ev;
	always_comb begin
		rx_state_nxt = rx_state_r;
		rx_blk_nxt   = rx_blk_r;
		rx_blk_ev    = 1'b0;
		unique case (rx_state_r)
			dha_pkg::DHA_RX_IDLE: begin
				if (rx_block_ready && term_mode && rx_block_code <= 3'h4) begin
					rx_blk_nxt   = dha_pkg::RX_BLOCK_MAX >> rx_block_code;
					rx_state_nxt = dha_pkg::DHA_RX_REQ;
				end
			end
			dha_pkg::DHA_RX_REQ: begin
				if (pop_a) begin
					rx_blk_nxt = rx_blk_r - 1'b1;
					if (rx_blk_r == 7'h01) begin
						rx_blk_ev    = 1'b1;
						rx_state_nxt = dha_pkg::DHA_RX_IDLE;
					end
				end
			end
			default: rx_state_nxt = dha_pkg::DHA_RX_IDLE;
		endcase
	end

	// Receive sequencer state.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rx_state_r <= dha_pkg::DHA_RX_IDLE;
			rx_blk_r   <= 7'h00;
		end else begin
			rx_state_r <= rx_state_nxt;
			rx_blk_r   <= rx_blk_nxt;
		end
	end

	// Sticky interrupt status; an event in the clearing cycle wins.
	logic [dha_pkg::IRQ_W-1:0] irq_set, irq_clr;
	always_comb begin
		irq_set = '0;
		irq_set[dha_pkg::IRQ_TX_DONE] = tx_done_ev;
		irq_set[dha_pkg::IRQ_TX_BLK]  = tx_blk_ev;
		irq_set[dha_pkg::IRQ_RX_BLK]  = rx_blk_ev;
		irq_clr = '0;
		if (wr_take && avs_address == dha_pkg::REG_IRQ_STAT) begin
			irq_clr = avs_writedata[dha_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_stat_r <= dha_pkg::IRQ_RST;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	// Interrupt outputs follow the next status so the pin and aux copy agree cycle for cycle.
	logic irq_nxt, int_pend;
	assign irq_nxt  = |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
	assign int_pend = irq_nxt | dev_int_pending;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			{irq, int_pin_out, int_pin_oe_n} <= 3'h1;
		end else begin
			irq          <= irq_nxt;
			int_pin_out  <= 1'b0;      // Open drain only ever pulls low.
			int_pin_oe_n <= ~int_pend;
		end
	end

	// Auxiliary pin drivers and channel select, per mode.
	logic tx_req_nxt, rx_req_nxt;
	assign tx_req_nxt = term_mode & (tx_state_nxt == dha_pkg::DHA_TX_REQ);
	assign rx_req_nxt = term_mode & (rx_state_nxt == dha_pkg::DHA_RX_REQ);
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			{aux_pin_out, aux_pin_oe_n, chan_sel} <= 9'h038;
		end else if (term_mode) begin
			aux_pin_out[0]    <= tx_req_nxt;
			aux_pin_out[1]    <= rx_req_nxt;
			aux_pin_oe_n[1:0] <= 2'h0;
			aux_pin_out[2]    <= (aux_pin_2_use_r == dha_pkg::AUX_PIN_2_INT) ? int_pend : gpio_out_r;
			aux_pin_oe_n[2]   <= (aux_pin_2_use_r == dha_pkg::AUX_PIN_2_GPIO_IN);
		end else begin
			{aux_pin_out, aux_pin_oe_n} <= 6'h07;
			chan_sel                    <= aux_s;
		end
	end

	// Avalon slave: one wait cycle, read data registered on the first request cycle.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
		end
	end

	// Read multiplexer; unmapped words read zero.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_take) begin
			avs_readdata <= 32'h0000_0000;
			unique case (avs_address)
				dha_pkg::REG_CTRL: begin
					avs_readdata[dha_pkg::CTRL_MODE_LSB +: 2] <= mode_r;
					avs_readdata[dha_pkg::CTRL_AUX_PIN_2_LSB +: 2] <= aux_pin_2_use_r;
				end
				dha_pkg::REG_TXBC_HI: avs_readdata[dha_pkg::BC_HI_W-1:0] <= txbc_r[dha_pkg::BC_W-1 -: dha_pkg::BC_HI_W];
				dha_pkg::REG_TXBC_LO: avs_readdata[dha_pkg::BC_LO_W-1:0] <= txbc_r[dha_pkg::BC_LO_W-1:0];
				dha_pkg::REG_IRQ_STAT: avs_readdata[dha_pkg::IRQ_W-1:0] <= irq_stat_r;
				dha_pkg::REG_IRQ_MASK: avs_readdata[dha_pkg::IRQ_W-1:0] <= irq_mask_r;
				dha_pkg::REG_PINS: begin
					avs_readdata[dha_pkg::PINS_AUX_PIN_2]       <= aux_s[2];
					avs_readdata[dha_pkg::PINS_CHSEL +: 3] <= chan_sel;
					avs_readdata[dha_pkg::PINS_TXBSY]      <= (tx_state_r != dha_pkg::DHA_TX_IDLE);
					avs_readdata[dha_pkg::PINS_RXBSY]      <= (rx_state_r != dha_pkg::DHA_RX_IDLE);
				end
				dha_pkg::REG_GPIO_OUT: avs_readdata[0] <= gpio_out_r;
				dha_pkg::REG_TX_LEFT: avs_readdata[dha_pkg::BC_W-1:0] <= tx_left_r;
				default: ;
			endcase
		end
	end
endmodule

`default_nettype wire

// ---- tb/dha_properties.sv ----
// Checker of the DMA handshake pins, bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module dha_properties (
	// Clock and reset.
	input wire logic       sys_clk,
	input wire logic       reset,
	// Acknowledge and host strobes.
	input wire logic       dma_ack_chan_a_n,
	input wire logic       host_rd_n,
	input wire logic       host_wr_n,
	// FIFO pulses, pins and interrupts.
	input wire logic       tx_push_chan_a,
	input wire logic       rx_pop_chan_a,
	input wire logic       reg_wr_pulse,
	input wire logic [2:0] aux_pin_out,
	input wire logic [2:0] aux_pin_oe_n,
	input wire logic       int_pin_out,
	input wire logic       int_pin_oe_n,
	input wire logic       irq
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Both strobes idle long enough that no access is left in the sync chain.
	sequence s_quiet;
		(host_rd_n && host_wr_n) [*5];
	endsequence
	// A driven request that has just dropped.
	sequence s_tx_drop;
		$fell(aux_pin_out[0]) && !aux_pin_oe_n[0];
	endsequence
	sequence s_rx_drop;
		$fell(aux_pin_out[1]) && !aux_pin_oe_n[1];
	endsequence
	property p_quiet;
		s_quiet |-> !tx_push_chan_a && !rx_pop_chan_a;
	endproperty
	a_quiet: assert property (p_quiet) else $error("FIFO access without strobe");
	property p_push_ack;
		tx_push_chan_a |-> !$past(dma_ack_chan_a_n, 3) && !reg_wr_pulse;
	endproperty
	a_push_ack: assert property (p_push_ack) else $error("push without acknowledge");
	property p_tx_drop;
		s_tx_drop |-> tx_push_chan_a;
	endproperty
	a_tx_drop: assert property (p_tx_drop) else $error("tx request fell without push");
	property p_rx_drop;
		s_rx_drop |-> rx_pop_chan_a;
	endproperty
	a_rx_drop: assert property (p_rx_drop) else $error("rx request fell without pop");
	property p_tx_hold;
		!aux_pin_oe_n[0] && aux_pin_out[0] ##1 !tx_push_chan_a |-> aux_pin_out[0];
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx request dropped early");
	property p_rx_hold;
		!aux_pin_oe_n[1] && aux_pin_out[1] ##1 !rx_pop_chan_a |-> aux_pin_out[1];
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx request dropped early");
	property p_int;
		irq |-> !int_pin_oe_n && !int_pin_out;
	endproperty
	a_int: assert property (p_int) else $error("main interrupt not asserted");
	property p_line;
		aux_pin_oe_n[0] |-> aux_pin_oe_n == 3'h7;
	endproperty
	a_line: assert property (p_line) else $error("aux pins not all inputs");
endmodule
bind dha_top dha_properties dha_properties_inst (.sys_clk, .reset, .dma_ack_chan_a_n, .host_rd_n, .host_wr_n,
	.tx_push_chan_a, .rx_pop_chan_a, .reg_wr_pulse, .aux_pin_out, .aux_pin_oe_n, .int_pin_out, .int_pin_oe_n, .irq);
`default_nettype wire

// ---- tb/dha_dma_model.sv ----
// DMA controller model that answers channel A requests with acknowledge and strobes.
`timescale 1ns/1ps
`default_nettype none
module dha_dma_model (
	// Clock, reset and pacing.
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       slow,
	// Requests from the device.
	input  wire logic [2:0] aux_pin_out,
	input  wire logic [2:0] aux_pin_oe_n,
	// Pins towards the device.
	output logic            dma_ack_chan_a_n,
	output logic            host_rd_n,
	output logic            host_wr_n,
	output logic      [7:0] host_addr,
	// Bytes moved so far.
	output int              n_wr,
	output int              n_rd
);
	// Strobes one byte at a time until the device drops its request.
	task automatic serve(input int b);
		dma_ack_chan_a_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		while (!aux_pin_oe_n[b] && aux_pin_out[b]) begin
			host_addr <= ~host_addr;
			host_wr_n <= (b != 0);
			host_rd_n <= (b == 0);
			repeat (3) @(posedge sys_clk);
			host_wr_n <= 1'b1;
			host_rd_n <= 1'b1;
			if (b == 0) n_wr++;
			else n_rd++;
			repeat (slow ? 8 : 4) @(posedge sys_clk);
		end
		dma_ack_chan_a_n <= 1'b1;
	endtask
	// Idle pins remainder_block high as if pulled up; transmit requests are served first.
	initial begin
		{dma_ack_chan_a_n, host_rd_n, host_wr_n} = 3'h7;
		host_addr = 8'h00;
		forever begin
			@(posedge sys_clk);
			if (!reset && !aux_pin_oe_n[0] && aux_pin_out[0]) serve(0);
			else if (!reset && !aux_pin_oe_n[1] && aux_pin_out[1]) serve(1);
		end
	end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench for the DMA handshake block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	// Bench signals.
	logic        sys_clk, reset, avs_read, avs_write, avs_waitrequest, dma_ack_chan_a_n, host_rd_n, host_wr_n;
	logic        slow, tx_fifo_room, rx_block_ready, dev_int_pending, int_pin_oe_n, irq;
	logic        host_cs_n, int_pin_out, tx_push_chan_a, rx_pop_chan_a, tx_push_chan_b, rx_pop_chan_b;
	logic        reg_rd_pulse, reg_wr_pulse;
	logic [7:0]  reg_addr;
	int          n_push, n_pop, n_regp;
	logic [2:0]  avs_address, rx_block_code, aux_pin_in, aux_pin_out, aux_pin_oe_n, chan_sel;
	logic [7:0]  host_addr;
	logic [31:0] avs_writedata, avs_readdata, rd_data;
	int          n_mismatch, n_checks, n_wr, n_rd, n_txblk, seed, cyc, cnt, w0, b0, i;
	dha_top dha_top_inst (.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .dma_ack_chan_a_n, .dma_ack_chan_b_n(1'b1), .host_cs_n, .host_rd_n, .host_wr_n,
		.host_addr, .tx_fifo_room, .rx_block_ready, .rx_block_code, .dev_int_pending, .tx_push_chan_a,
		.rx_pop_chan_a, .tx_push_chan_b, .rx_pop_chan_b, .reg_rd_pulse, .reg_wr_pulse, .reg_addr,
		.aux_pin_in, .aux_pin_out, .aux_pin_oe_n, .chan_sel, .int_pin_out, .int_pin_oe_n, .irq);
	dha_dma_model dha_dma_model_inst (.sys_clk, .reset, .slow, .aux_pin_out, .aux_pin_oe_n, .dma_ack_chan_a_n,
		.host_rd_n, .host_wr_n, .host_addr, .n_wr, .n_rd);
	// Clock.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Random FIFO room, and the guard against a hang.
	always @(posedge sys_clk) begin
		tx_fifo_room <= 1'($random(seed));
		n_push += int'(tx_push_chan_a);
		n_pop += int'(rx_pop_chan_a);
		n_regp += int'(reg_rd_pulse | reg_wr_pulse | tx_push_chan_b | rx_pop_chan_b);
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// Counts transmit block requests.
	always @(posedge aux_pin_out[0]) n_txblk++;
	// Counts and reports one comparison.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One Avalon transfer; read data land in rd_data.
	task automatic avm(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge sys_clk);
		while (avs_waitrequest)
			@(posedge sys_clk);
		rd_data = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// Polls the status register until the given bit is set.
	task automatic wait_stat(input int b);
		rd_data = 32'h0000_0000;
		repeat (3000)
			if (!rd_data[b]) avm(1'b0, dha_pkg::REG_IRQ_STAT, 32'h0000_0000);
	endtask
	// Expected transmit block count and receive block size.
	function automatic int n_blk(input int n);
		return (n + 63) / 64;
	endfunction
	function automatic int rx_bytes(input int c);
		return (c < 5) ? (64 >> c) : 0;
	endfunction
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		seed = 7;
		reset = 1'b1;
		// Chip select stays low all run, so every DMA strobe must still be kept off the registers.
		{host_cs_n, avs_read, avs_write, slow, tx_fifo_room, rx_block_ready, dev_int_pending} = 7'h00;
		{avs_address, rx_block_code, aux_pin_in} = 9'h000;
		avs_writedata = 32'h0000_0000;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("aux_pin_oe_n", 3'h4, aux_pin_oe_n);
		chk("int_pin_oe_n", 1, int_pin_oe_n);
		avm(1'b1, dha_pkg::REG_TX_LEFT, 32'h0000_0fff);
		avm(1'b0, dha_pkg::REG_TX_LEFT, 32'h0000_0000);
		chk("tx_left", 0, rd_data);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			cnt = (i < 2) ? 64 >> (6 * i) : {$random(seed)} % 200 + 1;
			slow <= i[0];
			w0 = n_wr;
			b0 = n_txblk;
			avm(1'b1, dha_pkg::REG_IRQ_MASK, (i == 3) ? 32'h0000_0000 : 32'h0000_0007);
			avm(1'b1, dha_pkg::REG_TXBC_HI, 32'(cnt >> 8));
			avm(1'b1, dha_pkg::REG_TXBC_LO, 32'(cnt & 255));
			avm(1'b1, dha_pkg::REG_CTRL, 32'h0000_0010);
			wait_stat(dha_pkg::IRQ_TX_DONE);
			repeat (12) @(posedge sys_clk);
			@(negedge sys_clk);
			chk("tx bytes", cnt, n_wr - w0);
			chk("tx blocks", n_blk(cnt), n_txblk - b0);
			chk("irq", i != 3, irq);
			chk("int_pin_oe_n", i == 3, int_pin_oe_n);
			avm(1'b1, dha_pkg::REG_IRQ_STAT, 32'h0000_0007);
			@(negedge sys_clk);
			chk("irq cleared", 0, irq);
			$display("test tx %0d done", i);
		end
		avm(1'b1, dha_pkg::REG_IRQ_MASK, 32'h0000_0007);
		for (i = 0; i < 6; i++) begin
			w0 = n_rd;
			slow <= i[0];
			rx_block_code <= 3'(i);
			rx_block_ready <= 1'b1;
			@(posedge sys_clk);
			rx_block_ready <= 1'b0;
			repeat (1000) @(posedge sys_clk);
			@(negedge sys_clk);
			chk("rx bytes", rx_bytes(i), n_rd - w0);
			chk("rx irq", i < 5, irq);
			avm(1'b1, dha_pkg::REG_IRQ_STAT, 32'h0000_0007);
		end
		$display("test rx done");
		for (i = 1; i < 4; i++) begin
			@(posedge sys_clk);
			aux_pin_in <= 3'($random(seed));
			avm(1'b1, dha_pkg::REG_CTRL, 32'(i));
			avm(1'b0, dha_pkg::REG_PINS, 32'h0000_0000);
			@(negedge sys_clk);
			chk("aux_pin_oe_n", 3'h7, aux_pin_oe_n);
			chk("chan_sel", aux_pin_in, chan_sel);
			chk("pins chan_sel", aux_pin_in, rd_data[3:1]);
		end
		$display("test line modes done");
		avm(1'b1, dha_pkg::REG_CTRL, {dha_pkg::AUX_PIN_2_GPIO_OUT, dha_pkg::MODE_TERMINAL});
		avm(1'b1, dha_pkg::REG_GPIO_OUT, 32'h0000_0001);
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk("aux_pin_oe_n", 3'h0, aux_pin_oe_n);
		chk("aux_pin_2 level", 1, aux_pin_out[2]);
		@(posedge sys_clk);
		aux_pin_in <= 3'h4;
		avm(1'b1, dha_pkg::REG_CTRL, {dha_pkg::AUX_PIN_2_GPIO_IN, dha_pkg::MODE_TERMINAL});
		avm(1'b0, dha_pkg::REG_PINS, 32'h0000_0000);
		chk("pins aux_pin_2", 1, rd_data[0]);
		avm(1'b1, dha_pkg::REG_CTRL, {dha_pkg::AUX_PIN_2_INT, dha_pkg::MODE_TERMINAL});
		for (i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			dev_int_pending <= !i[0];
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			chk("aux_pin_2 int", !i[0], aux_pin_out[2]);
			chk("int_pin_oe_n", i[0], int_pin_oe_n);
		end
		chk("int_pin_out", 0, int_pin_out);
		chk("tx pushes", n_wr, n_push);
		chk("rx pops", n_rd, n_pop);
		chk("reg and chan b pulses", 0, n_regp);
		chk("reg_addr", 0, reg_addr);
		$display("test aux_pin_2 done");
		complete_run();
	end
endmodule
`default_nettype wire
